// [shared/rof_pkg.sv]
/*
  package for the receive output formatter: symbol layout, modes, timing counts.
  assumes one core clock; recovered clock is produced by dividing it.
*/
package rof_pkg;

  // ----------------------------------------
  // symbol carried from the decoder side
  // ----------------------------------------
  typedef struct packed {
    logic pos_pulse;
    logic neg_pulse;
    logic data_bit;
    logic bipolar_violation;
    logic excess_zeros_event;
  } rof_sym_t;

  localparam int ROF_SYM_W = 5;

  // ----------------------------------------
  // modes and timing
  // ----------------------------------------
  localparam logic MODE_DUAL_RAIL   = 1'b0;
  localparam logic MODE_SINGLE_RAIL = 1'b1;
  localparam logic EDGE_RISING      = 1'b0;
  localparam logic EDGE_FALLING     = 1'b1;

  localparam int  CORE_CLK_PERIOD_NS = 40;
  localparam int  RCLK_HALF_CYCLES   = 2;
  localparam int  FIFO_DEPTH         = 16;
  localparam logic RST_CLK_OUT       = 1'b0;

  typedef enum logic [1:0] {
    ROF_LOW  = 2'b01,
    ROF_HIGH = 2'b10
  } rof_phase_t;

endpackage

// [verilog/rof_formatter.sv]
/*
  receive output formatter for one line channel, with its input fifo.
  assumes decoded symbols arrive on a valid/ready stream synchronous to core_clk.
*/
`timescale 1ns/10ps

// ----------------------------------------
// fifo
// ----------------------------------------
module rof_fifo
  #(parameter int WIDTH = 8,
    parameter int DEPTH = 16)
  (input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // count is one bit wider than the pointers so a full fifo reads DEPTH, not zero
  // ready follows occupancy only; a pop in the same cycle does not free a slot early
  assign in_ready  = (count_ff < (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // rof_fifo

// ----------------------------------------
// formatter top
// ----------------------------------------
module rof_formatter
  import rof_pkg::*;
  #(parameter int DEPTH = FIFO_DEPTH)
  (input  wire logic     core_clk,
   input  wire logic     srst,
   input  wire logic     single_rail_mode,
   input  wire logic     launch_on_falling,
   input  wire rof_sym_t sym_in,
   input  wire logic     sym_valid,
   output      logic     sym_ready,
   output      logic     recovered_clk_out,
   output      logic     rx_positive_out,
   output      logic     rx_negative_out);

  rof_sym_t   fifo_sym;
  logic       fifo_valid;
  logic       fifo_take;
  logic [1:0] div_cnt_ff;
  rof_phase_t phase_ff;
  logic       launch;
  logic       code_violation_flag;
  logic       nxt_pos;
  logic       nxt_neg;

  rof_fifo #(.WIDTH(ROF_SYM_W), .DEPTH(DEPTH)) u_fifo
  (.core_clk  (core_clk),
   .srst      (srst),
   .in_data   (sym_in),
   .in_valid  (sym_valid),
   .in_ready  (sym_ready),
   .out_data  (fifo_sym),
   .out_valid (fifo_valid),
   .out_ready (fifo_take));

  // ----------------------------------------
  // recovered clock divider
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      div_cnt_ff <= '0;
      phase_ff   <= ROF_LOW;
    end
    else if (div_cnt_ff == 2'(RCLK_HALF_CYCLES - 1))
    begin
      div_cnt_ff <= '0;
      case (phase_ff)
        ROF_LOW:  phase_ff <= ROF_HIGH;
        ROF_HIGH: phase_ff <= ROF_LOW;
        default:  phase_ff <= ROF_LOW;
      endcase
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      recovered_clk_out <= RST_CLK_OUT;
    end
    else if (div_cnt_ff == 2'(RCLK_HALF_CYCLES - 1))
    begin
      // toggles with phase_ff so the pin edge and the data launch share one core edge
      recovered_clk_out <= (phase_ff == ROF_LOW);
    end
  end

  // launch marks the core cycle in which the selected clock edge appears
  // at the pin; outputs and clock flip together, so the far end samples
  // a half period later on the opposite edge
  assign launch = (div_cnt_ff == 2'(RCLK_HALF_CYCLES - 1)) &&
                  ((phase_ff == ROF_LOW) ? (launch_on_falling == EDGE_RISING)
                                         : (launch_on_falling == EDGE_FALLING));

  // an empty fifo underruns as zeros: the line had no pulse that period
  assign fifo_take = launch;

  // ----------------------------------------
  // rail formatting
  // ----------------------------------------
  assign code_violation_flag = fifo_sym.bipolar_violation || fifo_sym.excess_zeros_event;

  always_comb
  begin
    nxt_pos = 1'b0;
    nxt_neg = 1'b0;
    if (fifo_valid)
    begin
      if (single_rail_mode == MODE_SINGLE_RAIL)
      begin
        nxt_pos = fifo_sym.data_bit;
        nxt_neg = code_violation_flag;
      end
      else
      begin
        nxt_pos = fifo_sym.pos_pulse;
        nxt_neg = fifo_sym.neg_pulse;
      end
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // underrun and reset both leave the pins low, so the far end sees no pulse
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_positive_out <= 1'b0;
    end
    else if (launch)
    begin
      rx_positive_out <= nxt_pos;
    end
  end

  // a run of violations keeps the flag high across periods
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rx_negative_out <= 1'b0;
    end
    else if (launch)
    begin
      rx_negative_out <= nxt_neg;
    end
  end

endmodule // rof_formatter

// [verif/rof_chk.sv]
/*
  port timing checks for rof_formatter.
  assumes bind to rof_formatter ports.
*/
`timescale 1ns/10ps
module rof_chk
  (input wire logic core_clk,
   input wire logic srst,
   input wire logic single_rail_mode,
   input wire logic launch_on_falling,
   input wire logic sym_valid,
   input wire logic sym_ready,
   input wire logic recovered_clk_out,
   input wire logic rx_positive_out,
   input wire logic rx_negative_out);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire lvl = !launch_on_falling;
  chk_clk_hi: assert property ($rose(recovered_clk_out)
    |=> recovered_clk_out ##1 !recovered_clk_out) else $error("clock high time");
  chk_clk_lo: assert property ($fell(recovered_clk_out)
    |=> !recovered_clk_out ##1 recovered_clk_out) else $error("clock low time");
  chk_clk_period: assert property ($rose(recovered_clk_out)
    |-> ##4 $rose(recovered_clk_out)) else $error("clock period");
  chk_pos_edge: assert property ($changed(rx_positive_out)
    |-> $changed(recovered_clk_out) && recovered_clk_out == lvl) else $error("pos edge");
  chk_neg_edge: assert property ($changed(rx_negative_out)
    |-> $changed(recovered_clk_out) && recovered_clk_out == lvl) else $error("neg edge");
  chk_pos_hold: assert property ($changed(rx_positive_out)
    |=> $stable(rx_positive_out)[*3]) else $error("pos hold");
  chk_neg_hold: assert property ($rose(rx_negative_out)
    |=> rx_negative_out[*3]) else $error("neg hold");
  chk_edge_sel: assert property ($rose(recovered_clk_out) && launch_on_falling
    |-> $stable(rx_positive_out) && $stable(rx_negative_out)) else $error("edge select");
  cover property ($rose(rx_negative_out) && single_rail_mode);
  cover property ($rose(rx_negative_out) && !single_rail_mode);
  cover property ($fell(sym_ready) && sym_valid);
endmodule // rof_chk
bind rof_formatter rof_chk rof_chk_inst (.core_clk(core_clk), .srst(srst),
  .single_rail_mode(single_rail_mode), .launch_on_falling(launch_on_falling),
  .sym_valid(sym_valid), .sym_ready(sym_ready), .recovered_clk_out(recovered_clk_out),
  .rx_positive_out(rx_positive_out), .rx_negative_out(rx_negative_out));

// [verif/rof_sink.sv]
/*
  far-end model: samples the outputs on the edge opposite to launch.
  assumes edge select held still while running.
*/
`timescale 1ns/10ps
module rof_sink
  (input wire logic srst,
   input wire logic launch_on_falling,
   input wire logic recovered_clk_out,
   input wire logic rx_positive_out,
   input wire logic rx_negative_out);
  logic [1:0] got[$];
  // half a period after launch the outputs are settled
  always @(recovered_clk_out)
    if (!srst && recovered_clk_out === launch_on_falling)
      got.push_back({rx_positive_out, rx_negative_out});
endmodule // rof_sink

// [verif/lineif_receive_output_formatter_tb_top.sv]
/*
  testbench for rof_formatter: all mode and edge settings, fifo filled until refused.
  assumes rof_sink as far end.
*/
`timescale 1ns/10ps
module lineif_receive_output_formatter_tb_top;
  import rof_pkg::*;
  logic core_clk = 0, srst = 1, single_rail_mode = 0, launch_on_falling = 0, sym_valid = 0;
  rof_sym_t sym_in = '0;
  logic sym_ready, recovered_clk_out, rx_positive_out, rx_negative_out;
  logic [1:0] exp_q[$];
  int fail_count = 0, checks = 0, seed = 87927;
  rof_formatter rof_formatter_inst (.core_clk(core_clk), .srst(srst),
    .single_rail_mode(single_rail_mode), .launch_on_falling(launch_on_falling),
    .sym_in(sym_in), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .recovered_clk_out(recovered_clk_out), .rx_positive_out(rx_positive_out),
    .rx_negative_out(rx_negative_out));
  rof_sink rof_sink_inst (.srst(srst), .launch_on_falling(launch_on_falling),
    .recovered_clk_out(recovered_clk_out), .rx_positive_out(rx_positive_out),
    .rx_negative_out(rx_negative_out));
  initial forever #20 core_clk = ~core_clk;
  task cmp(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task run(input logic m, input logic e);
    rof_sym_t s;
    srst <= 1;
    single_rail_mode <= m;
    launch_on_falling <= e;
    repeat (8) @(posedge core_clk);
    srst <= 0;
    @(posedge core_clk);
    for (int i = 0; i < 28; i++)
    begin
      s = rof_sym_t'(5'($random(seed)));
      // first symbol nonzero marks where the stream starts
      if (i == 0) s = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      if (!m && s.pos_pulse) s.neg_pulse = 0;
      sym_in <= s;
      sym_valid <= 1;
      @(negedge core_clk);
      if (sym_ready) exp_q.push_back(m ? {s.data_bit, s.bipolar_violation
        | s.excess_zeros_event} : {s.pos_pulse, s.neg_pulse});
      if (i == 26) cmp({1'b0, sym_ready}, 2'h0);
      @(posedge core_clk);
    end
    sym_valid <= 0;
    repeat (80) @(posedge core_clk);
    while (rof_sink_inst.got.size() > 0 && rof_sink_inst.got[0] === 2'h0)
      void'(rof_sink_inst.got.pop_front());
    while (exp_q.size() > 0)
      cmp(rof_sink_inst.got.size() > 0 ? rof_sink_inst.got.pop_front() : 2'hX,
        exp_q.pop_front());
    rof_sink_inst.got.delete();
  endtask
  initial
  begin
    for (int k = 0; k < 4; k++)
      run(k[1], k[0]);
    finish_test();
  end
  initial
  begin
    #(40 * 2000);
    fail_count++;
    finish_test();
  end
endmodule // lineif_receive_output_formatter_tb_top
